// ---- timer_consts.vh ----
// Register map, field positions and encodings for the 16-bit timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register byte offsets
`define OFS_CONTROL_ZERO   8'h00
`define OFS_CONTROL_ONE    8'h04
`define OFS_COUNTER_LOW    8'h08
`define OFS_COUNTER_HIGH   8'h0C
`define OFS_COMPARE_A_LOW  8'h10
`define OFS_COMPARE_A_HIGH 8'h14
`define OFS_COMPARE_P      8'h18
`define OFS_STATUS         8'h1C
`define OFS_PRESCALE       8'h20

// Control zero fields
`define BIT_COUNTER_ENABLE 3
`define BIT_EXT_TRIG_EN    0

// Control one fields
`define BIT_MODE_HI        7
`define BIT_MODE_LO        6
`define BIT_PINF_HI        5
`define BIT_PINF_LO        4
`define BIT_INIT_LEVEL     3
`define BIT_OUT_INVERT     2
`define BIT_PERIOD_SWAP    1
`define BIT_CLEAR_SELECT   0

// Status fields, write one to clear
`define BIT_MATCH_A        0
`define BIT_MATCH_P        1

// Mode encodings
`define MODE_COMPARE       2'h0
`define MODE_CAPTURE       2'h1
`define MODE_PWM_PULSE     2'h2
`define MODE_TIMER         2'h3

// Pin function encodings
`define PINF_NONE          2'h0
`define PINF_LOW           2'h1
`define PINF_HIGH          2'h2
`define PINF_TOGGLE        2'h3
`define PINF_PWM_INACTIVE  2'h0
`define PINF_PWM_ACTIVE    2'h1
`define PINF_PWM_OUT       2'h2
`define PINF_PULSE         2'h3

// Reset values and constants
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000
`define RST_PRESCALE       8'h00
`define ZERO_BYTE          8'h00
`define ONE_WORD           16'h0001
`define FULL_DUTY          17'h10000

`endif

// ---- std_timer.v ----
// Standard 16-bit timer with two comparators and a classic Wishbone slave
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "timer_consts.vh"

module std_timer (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire        ack_o,
   // Timer pins
   input  wire        external_clock_pin_i,
   output wire        timer_out_o,
   output wire        timer_out_oe_o
);

   // Bus state
   reg  [31:0] dat_q;
   reg         ack_q;
   // Control fields
   reg         counter_enable_q;
   reg         enable_prev_q;
   reg         ext_trig_en_q;
   reg  [1:0]  mode_select_q;
   reg  [1:0]  pin_function_q;
   reg         output_initial_level_q;
   reg         output_invert_q;
   reg         period_duty_swap_q;
   reg         clear_select_q;
   // Data registers
   reg  [15:0] counter_q;
   reg  [15:0] compare_value_a_q;
   reg  [7:0]  compare_value_p_q;
   reg  [7:0]  prescale_q;
   reg  [7:0]  div_q;
   reg         match_a_flag_q;
   reg         match_p_flag_q;
   // Pin state
   reg         cmp_pin_q;
   reg         timer_out_q;
   reg         ext_s1_q;
   reg         ext_s2_q;
   reg         ext_s3_q;

   // Next values
   reg  [15:0] counter_d;
   reg         counter_enable_d;
   reg         cmp_pin_d;
   reg         timer_out_d;
   reg  [31:0] dat_d;

   wire        req;
   wire        wr_go;
   wire        wr_byte;
   wire        tick;
   wire        en_rise;
   wire        ext_rise;
   wire [15:0] counter_inc;
   wire        a_hit;
   wire        p_hit;
   wire        mode_cmp;
   wire        mode_pwm;
   wire        mode_pulse;
   wire        clear_on_a;
   wire        count_step;
   wire [16:0] duty_p;
   wire        duty_active;
   wire        pwm_level;
   wire        set_a;
   wire        set_p;
   wire        clr_a;
   wire        clr_p;

   assign req     = cyc_i & stb_i;
   // Write lands on the edge where the master sees ack
   assign wr_go   = req & we_i & ack_q;
   assign wr_byte = wr_go & sel_i[0];
   assign ack_o   = ack_q;
   assign dat_o   = dat_q;

   // Timer tick from prescaler, divide by prescale plus one
   assign tick = (div_q == prescale_q);

   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= `RST_PRESCALE;
      end else if (tick) begin
         div_q <= `ZERO_BYTE;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // External pin synchroniser, edge taken after second stage only
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= external_clock_pin_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_s3_q;

   assign mode_cmp   = (mode_select_q == `MODE_COMPARE) | (mode_select_q == `MODE_TIMER);
   assign mode_pwm   = (mode_select_q == `MODE_PWM_PULSE) & (pin_function_q != `PINF_PULSE);
   assign mode_pulse = (mode_select_q == `MODE_PWM_PULSE) & (pin_function_q == `PINF_PULSE);

   assign en_rise    = counter_enable_q & ~enable_prev_q;
   assign count_step = counter_enable_q & ~en_rise & tick;

   // compare A against all sixteen bits
   assign counter_inc = counter_q + `ONE_WORD;
   assign a_hit = count_step & (counter_inc == compare_value_a_q);
   // compare P against top byte; zero means overflow
   assign p_hit = count_step & (counter_inc[15:8] == compare_value_p_q)
                  & (counter_inc[7:0] == `ZERO_BYTE);

   // in PWM swap low clears on P, swap high on A; other modes follow clear select, and pulse never clears
   assign clear_on_a = mode_pwm ? period_duty_swap_q : clear_select_q;

   // Counter update
   always @* begin
      counter_d = counter_q;
      if (en_rise) begin
         counter_d = `RST_WORD;
      end else if (count_step) begin
         counter_d = counter_inc;
         // outside pulse mode, clear on P match or overflow, or on A match, as clear_on_a picks
         if (!mode_pulse && !clear_on_a && p_hit) begin
            counter_d = `RST_WORD;
         end
         if (!mode_pulse && clear_on_a && a_hit) begin
            counter_d = `RST_WORD;
         end
      end
   end

   // Match flags, set wins over clear
   // both flags in PWM; no P flag in pulse mode, nor with clear-select high in compare or timer mode
   assign set_a = a_hit;
   assign set_p = p_hit & ~(mode_cmp & clear_select_q) & ~mode_pulse;
   assign clr_a = wr_byte & (adr_i == `OFS_STATUS) & dat_i[`BIT_MATCH_A];
   assign clr_p = wr_byte & (adr_i == `OFS_STATUS) & dat_i[`BIT_MATCH_P];

   // PWM duty: P duty is 256 times P, or 65536 when zero
   assign duty_p = (compare_value_p_q == `ZERO_BYTE) ? `FULL_DUTY
                                                    : {1'b0, compare_value_p_q, `ZERO_BYTE};
   // duty A, or duty P when swapped; duty at or above period stays active
   assign duty_active = period_duty_swap_q ? ({1'b0, counter_q} < duty_p)
                                           : (counter_q < compare_value_a_q);

   assign pwm_level = (pin_function_q == `PINF_PWM_INACTIVE) ? ~output_initial_level_q :
                      (pin_function_q == `PINF_PWM_ACTIVE)   ? output_initial_level_q :
                      (duty_active ? output_initial_level_q : ~output_initial_level_q);

   // Enable bit: software write, pin trigger, A match in pulse mode
   always @* begin
      counter_enable_d = counter_enable_q;
      // pin sets enable in pulse mode
      if (mode_pulse && ext_trig_en_q && ext_rise) begin
         counter_enable_d = 1'b1;
      end
      if (mode_pulse && a_hit) begin
         counter_enable_d = 1'b0;
      end
      // Software write has the last word
      if (wr_byte && (adr_i == `OFS_CONTROL_ZERO)) begin
         counter_enable_d = dat_i[`BIT_COUNTER_ENABLE];
      end
   end

   // Compare output pin
   always @* begin
      cmp_pin_d = cmp_pin_q;
      if (en_rise) begin
         cmp_pin_d = output_initial_level_q;
      end else if (a_hit) begin
         // after the load at start, only an A match moves the pin; per pin function
         case (pin_function_q)
            `PINF_LOW:    cmp_pin_d = 1'b0;
            `PINF_HIGH:   cmp_pin_d = 1'b1;
            `PINF_TOGGLE: cmp_pin_d = ~cmp_pin_q;
            default:      cmp_pin_d = cmp_pin_q;
         endcase
      end
   end

   // Final pin level, registered
   always @* begin
      if (mode_pulse) begin
         timer_out_d = counter_enable_q ? output_initial_level_q : ~output_initial_level_q;
      end else if (mode_pwm) begin
         timer_out_d = pwm_level;
      end else begin
         timer_out_d = cmp_pin_d;
      end
      timer_out_d = timer_out_d ^ output_invert_q;
   end

   // pin released in timer mode; capture mode is not built
   assign timer_out_oe_o = (mode_select_q == `MODE_COMPARE) |
                           (mode_select_q == `MODE_PWM_PULSE);
   assign timer_out_o    = timer_out_q;

   // Read mux, unmapped offsets read zero
   always @* begin
      dat_d = {32{1'b0}};
      case (adr_i)
         `OFS_CONTROL_ZERO: begin
            dat_d[`BIT_COUNTER_ENABLE] = counter_enable_q;
            dat_d[`BIT_EXT_TRIG_EN]    = ext_trig_en_q;
         end
         `OFS_CONTROL_ONE: begin
            dat_d[`BIT_MODE_HI]      = mode_select_q[1];
            dat_d[`BIT_MODE_LO]      = mode_select_q[0];
            dat_d[`BIT_PINF_HI]      = pin_function_q[1];
            dat_d[`BIT_PINF_LO]      = pin_function_q[0];
            dat_d[`BIT_INIT_LEVEL]   = output_initial_level_q;
            dat_d[`BIT_OUT_INVERT]   = output_invert_q;
            dat_d[`BIT_PERIOD_SWAP]  = period_duty_swap_q;
            dat_d[`BIT_CLEAR_SELECT] = clear_select_q;
         end
         `OFS_COUNTER_LOW:    dat_d[7:0] = counter_q[7:0];
         `OFS_COUNTER_HIGH:   dat_d[7:0] = counter_q[15:8];
         `OFS_COMPARE_A_LOW:  dat_d[7:0] = compare_value_a_q[7:0];
         `OFS_COMPARE_A_HIGH: dat_d[7:0] = compare_value_a_q[15:8];
         `OFS_COMPARE_P:      dat_d[7:0] = compare_value_p_q;
         `OFS_STATUS: begin
            dat_d[`BIT_MATCH_A] = match_a_flag_q;
            dat_d[`BIT_MATCH_P] = match_p_flag_q;
         end
         `OFS_PRESCALE:       dat_d[7:0] = prescale_q;
         default:             dat_d = {32{1'b0}};
      endcase
   end

   // Bus answer one cycle after request, dropped the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= {32{1'b0}};
      end else begin
         ack_q <= req & ~ack_q;
         // Loaded on reads only, so writes leave the last read data standing
         if (req && !ack_q && !we_i) begin
            dat_q <= dat_d;
         end
      end
   end

   // Register and state update
   always @(posedge clk_i) begin
      if (rst_i) begin
         counter_enable_q       <= 1'b0;
         enable_prev_q          <= 1'b0;
         ext_trig_en_q          <= 1'b0;
         mode_select_q          <= `MODE_COMPARE;
         pin_function_q         <= `PINF_NONE;
         output_initial_level_q <= 1'b0;
         output_invert_q        <= 1'b0;
         period_duty_swap_q     <= 1'b0;
         clear_select_q         <= 1'b0;
         counter_q              <= `RST_WORD;
         compare_value_a_q      <= `RST_WORD;
         compare_value_p_q      <= `RST_BYTE;
         prescale_q             <= `RST_PRESCALE;
         match_a_flag_q         <= 1'b0;
         match_p_flag_q         <= 1'b0;
         cmp_pin_q              <= 1'b0;
         timer_out_q            <= 1'b0;
      end else begin
         counter_enable_q <= counter_enable_d;
         enable_prev_q    <= counter_enable_q;
         counter_q        <= counter_d;
         cmp_pin_q        <= cmp_pin_d;
         timer_out_q      <= timer_out_d;
         // sticky flags, set wins over clear
         match_a_flag_q   <= (match_a_flag_q & ~clr_a) | set_a;
         match_p_flag_q   <= (match_p_flag_q & ~clr_p) | set_p;
         if (wr_byte) begin
            case (adr_i)
               `OFS_CONTROL_ZERO: begin
                  ext_trig_en_q <= dat_i[`BIT_EXT_TRIG_EN];
               end
               `OFS_CONTROL_ONE: begin
                  mode_select_q          <= dat_i[`BIT_MODE_HI:`BIT_MODE_LO];
                  pin_function_q         <= dat_i[`BIT_PINF_HI:`BIT_PINF_LO];
                  output_initial_level_q <= dat_i[`BIT_INIT_LEVEL];
                  output_invert_q        <= dat_i[`BIT_OUT_INVERT];
                  period_duty_swap_q     <= dat_i[`BIT_PERIOD_SWAP];
                  clear_select_q         <= dat_i[`BIT_CLEAR_SELECT];
               end
               `OFS_COMPARE_A_LOW:  compare_value_a_q[7:0]  <= dat_i[7:0];
               `OFS_COMPARE_A_HIGH: compare_value_a_q[15:8] <= dat_i[7:0];
               `OFS_COMPARE_P:      compare_value_p_q <= dat_i[7:0];
               `OFS_PRESCALE:       prescale_q <= dat_i[7:0];
               default:             prescale_q <= prescale_q;
            endcase
         end
      end
   end

endmodule // std_timer

// ---- std_timer_props.sv ----
// Checker for the timer's bus answers and pin enable
`timescale 1ns/1ps
`include "timer_consts.vh"
module std_timer_props (
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // Bus
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   // Pins
   input wire        external_clock_pin_i,
   input wire        timer_out_o,
   input wire        timer_out_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence ctrl1_wr;
      ack_o && we_i && sel_i[0] && adr_i == `OFS_CONTROL_ONE;
   endsequence
   sequence rd_done;
      ack_o && !we_i;
   endsequence
   AST_ACK_NEXT: assert property (bus_req |=> ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   AST_READ_BYTE: assert property (rd_done |-> dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   // data moves only with a read
   AST_DATA_HOLD: assert property (!$stable(dat_o) |-> rd_done)
      else $error("read data changed without read");
   AST_RESET_STATE: assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0
      && !timer_out_o && timer_out_oe_o)
      else $error("outputs wrong after reset");
   AST_PIN_FREE: assert property (ctrl1_wr |=> timer_out_oe_o == !$past(dat_i[6]))
      else $error("pin enable wrong for mode");
   AST_UNMAPPED: assert property (rd_done and adr_i > `OFS_PRESCALE |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule // std_timer_props

bind std_timer std_timer_props i_props (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .external_clock_pin_i(external_clock_pin_i), .timer_out_o(timer_out_o),
   .timer_out_oe_o(timer_out_oe_o)
);

// ---- std_timer_tb.sv ----
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "timer_consts.vh"
module std_timer_tb;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc_i = 1'b0;
   reg         stb_i = 1'b0;
   reg         we_i = 1'b0;
   reg  [7:0]  adr_i = 8'h00;
   reg  [3:0]  sel_i = 4'h0;
   reg  [31:0] dat_i = 32'h0;
   reg         ext_i = 1'b0;
   wire [31:0] dat_o;
   wire        ack_o;
   wire        tout;
   wire        toe;
   integer     fail_count = 0;
   integer     n_checks = 0;
   reg  [31:0] seed = 32'hC1D9;
   reg  [7:0]  mdl [0:8];
   reg  [7:0]  q;
   reg  [7:0]  lo;
   integer     i;
   integer     v;

   always #50 clk_i = ~clk_i;

   std_timer i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .external_clock_pin_i(ext_i), .timer_out_o(tout), .timer_out_oe_o(toe)
   );

   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task finish_test;
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input string what, input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task wb(input w, input [7:0] a, input [7:0] d);
      integer t;
      t = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && t < 40) begin
         t = t + 1;
         @(posedge clk_i);
      end
      if (t >= 40) fail_count = fail_count + 1;
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (w && a >= `OFS_COMPARE_A_LOW && a <= `OFS_COMPARE_P) mdl[a[7:2]] = d;
   endtask

   task wr(input [7:0] a, input [7:0] d);
      wb(1'b1, a, d);
   endtask

   task rc(input [7:0] a, input [7:0] e);
      wb(1'b0, a, 8'h00);
      chk("reg", q, e);
   endtask

   // Stop, configure, clear flags, restart from zero
   task go(input [7:0] c1, input [15:0] a, input [7:0] p);
      wr(`OFS_CONTROL_ZERO, 8'h00);
      wr(`OFS_CONTROL_ONE, c1);
      wr(`OFS_COMPARE_A_LOW, a[7:0]);
      wr(`OFS_COMPARE_A_HIGH, a[15:8]);
      wr(`OFS_COMPARE_P, p);
      wr(`OFS_STATUS, 8'h03);
      wr(`OFS_CONTROL_ZERO, 8'h08);
   endtask

   // Long run, then stopped counter must hold and stay below its clear point
   task run(input [7:0] c1, input [15:0] a, input [7:0] st, input integer lim, input pin);
      go(c1, a, 8'h01);
      repeat (900) @(posedge clk_i);
      chk("pin", tout, pin);
      chk("oe", toe, c1[7:6] != 2'b11);
      wr(`OFS_CONTROL_ZERO, 8'h00);
      wb(1'b0, `OFS_COUNTER_LOW, 8'h00);
      lo = q;
      wb(1'b0, `OFS_COUNTER_HIGH, 8'h00);
      chk("count range", {q, lo} < lim, 1);
      repeat (10) @(posedge clk_i);
      rc(`OFS_COUNTER_LOW, lo);
      rc(`OFS_STATUS, st);
      wr(`OFS_STATUS, 8'h03);
      rc(`OFS_STATUS, 8'h00);
   endtask

   // Active cycles over whole periods, then flags
   task pwm(input [7:0] c1, input [15:0] a, input integer win, input integer ones,
            input [7:0] st);
      integer n;
      integer c;
      go(c1, a, 8'h01);
      repeat (20) @(posedge clk_i);
      c = 0;
      for (n = 0; n < win; n = n + 1) begin
         @(posedge clk_i);
         c = c + tout;
      end
      chk("pwm active", c, ones);
      wr(`OFS_CONTROL_ZERO, 8'h00);
      rc(`OFS_STATUS, st);
   endtask

   // Hang guard at 30000 cycles, well beyond the roughly 8200 cycles needed
   initial begin
      #3000000;
      fail_count = fail_count + 1;
      finish_test;
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
         mdl[i] = 8'h00;
         rc(8'(i * 4), 8'h00);
      end
      for (i = 4; i < 7; i = i + 1) begin
         seed = lfsr(seed);
         wr(8'(i * 4), seed[7:0]);
         rc(8'(i * 4), mdl[i]);
      end
      wr(`OFS_COUNTER_HIGH, 8'h5A);
      wr(8'h24, 8'hA5);
      rc(`OFS_COUNTER_HIGH, 8'h00);
      rc(8'h24, 8'h00);
      // Prescaler: one step per four clocks over 402 counting edges
      wr(`OFS_PRESCALE, 8'h03);
      rc(`OFS_PRESCALE, 8'h03);
      go(8'h00, 16'h1000, 8'h00);
      repeat (400) @(posedge clk_i);
      wr(`OFS_CONTROL_ZERO, 8'h00);
      wb(1'b0, `OFS_COUNTER_LOW, 8'h00);
      lo = q;
      rc(`OFS_COUNTER_HIGH, 8'h00);
      chk("prescaled count", (lo == 8'h64) || (lo == 8'h65), 1);
      wr(`OFS_PRESCALE, 8'h00);
      // Every pin function, initial level opposite the action where it matters
      for (i = 0; i < 4; i = i + 1) begin
         v = (i < 2);
         go({2'b00, 2'(i), 1'(v), 3'b001}, 16'd40, 8'h00);
         repeat (3) @(posedge clk_i);
         chk("pin init", tout, v);
         repeat (55) @(posedge clk_i);
         chk("pin match", tout, (i == 0) ? v : (i == 1) ? 0 : (i == 2) ? 1 : !v);
      end
      run(8'h20, 16'h012C, 8'h02, 256, 1'b0);
      run(8'hC0, 16'h0020, 8'h03, 256, 1'b0);
      run(8'h01, 16'h0180, 8'h01, 384, 1'b0);
      pwm(8'hA8, 16'h0040, 512, 128, 8'h03);
      pwm(8'hAC, 16'h0040, 512, 384, 8'h03);
      pwm(8'hA0, 16'h0040, 512, 384, 8'h03);
      pwm(8'hA9, 16'h0200, 512, 512, 8'h02);
      pwm(8'hAA, 16'h0200, 1024, 512, 8'h03);
      pwm(8'h88, 16'h0040, 512, 0, 8'h03);
      pwm(8'h98, 16'h0040, 512, 512, 8'h03);
      // Pulse ended by compare A, then by software
      go(8'hB8, 16'd50, 8'h00);
      repeat (3) @(posedge clk_i);
      chk("pulse lead", tout, 1);
      repeat (100) @(posedge clk_i);
      chk("pulse trail", tout, 0);
      rc(`OFS_CONTROL_ZERO, 8'h00);
      wr(`OFS_CONTROL_ZERO, 8'h01);
      ext_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("ext lead", tout, 1);
      rc(`OFS_CONTROL_ZERO, 8'h09);
      ext_i <= 1'b0;
      wr(`OFS_CONTROL_ZERO, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("sw trail", tout, 0);
      finish_test;
   end
endmodule // std_timer_tb
